/* rtl/gcc_ctrl.sv */
// Readback register and conversion control register with self-clearing bits
`timescale 1ns/1ps
module gcc_ctrl
  import gcc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire gcc_wr_t     wr_i,
  input  wire logic [7:0]  rd_addr_i,
  input  wire logic [1:0]  pin_a1_level_i,
  input  wire logic [1:0]  pin_a0_level_i,
  input  wire logic [1:0]  pin_b1_level_i,
  input  wire logic [1:0]  pin_b0_level_i,
  input  wire gcc_chan_t   chan1_i,
  input  wire gcc_chan_t   chan2_i,
  input  wire logic        seq_busy_i,
  output logic [15:0]      rd_data_o,
  output logic             chan1_start_o,
  output logic             chan2_start_o,
  output logic             chan1_stop_o,
  output logic             chan2_stop_o,
  output logic             seq_start_o,
  output logic             seq_stop_o
);

  // -------------------------------------------------------------------------
  // Write decode
  // -------------------------------------------------------------------------
  logic ctrl_wr;
  logic w_go1;
  logic w_go2;
  logic w_halt1;
  logic w_halt2;
  logic w_sgo;
  logic w_shalt;

  assign ctrl_wr = wr_i.valid && (wr_i.addr == GCC_ADDR_CONV_CTRL);
  assign w_go1   = ctrl_wr && wr_i.data[GCC_BIT_CH1_GO];
  assign w_go2   = ctrl_wr && wr_i.data[GCC_BIT_CH2_GO];
  assign w_halt1 = ctrl_wr && wr_i.data[GCC_BIT_CH1_HALT];
  assign w_halt2 = ctrl_wr && wr_i.data[GCC_BIT_CH2_HALT];
  assign w_sgo   = ctrl_wr && wr_i.data[GCC_BIT_SEQ_GO];
  assign w_shalt = ctrl_wr && wr_i.data[GCC_BIT_SEQ_HALT];

  // -------------------------------------------------------------------------
  // Start strobes: one-cycle pulses, never stored, so they read as zero
  // -------------------------------------------------------------------------
  assign chan1_start_o = w_go1 && chan1_i.enabled;
  assign chan2_start_o = w_go2 && chan2_i.enabled;
  assign seq_start_o   = w_sgo;

  // -------------------------------------------------------------------------
  // Halt bits: pending until the running conversion ends or a go arrives
  // -------------------------------------------------------------------------
  logic halt1_q;
  logic halt2_q;
  logic shalt_q;

  // Channel 1 halt; go in the same frame wins, single-shot ignores it
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      halt1_q <= 1'b0;
    else if (w_go1)
      halt1_q <= 1'b0;
    else if (w_halt1 && chan1_i.continuous)
      halt1_q <= 1'b1;
    else if (chan1_i.done || !chan1_i.busy)
      halt1_q <= 1'b0;
  end

  // Channel 2 halt mirrors channel 1
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      halt2_q <= 1'b0;
    else if (w_go2)
      halt2_q <= 1'b0;
    else if (w_halt2 && chan2_i.continuous)
      halt2_q <= 1'b1;
    else if (chan2_i.done || !chan2_i.busy)
      halt2_q <= 1'b0;
  end

  // Sequencer halt: held while the sequence runs, cleared by a go
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      shalt_q <= 1'b0;
    else if (w_sgo)
      shalt_q <= 1'b0;
    else if (w_shalt)
      shalt_q <= 1'b1;
    else if (!seq_busy_i)
      shalt_q <= 1'b0;
  end

  // Converter sees a halt request; it finishes the current conversion
  // and then stops, since the halt never forces an abort by itself
  assign chan1_stop_o = halt1_q;
  assign chan2_stop_o = halt2_q;
  assign seq_stop_o   = shalt_q;

  // -------------------------------------------------------------------------
  // Readback: pin levels and pending halt bits
  // -------------------------------------------------------------------------
  logic [15:0] pins_w;
  logic [15:0] ctrl_w;

  // Four two-bit level fields, reserved bits zero
  always_comb
  begin
    pins_w = GCC_READBACK_RESET;
    pins_w[GCC_POS_A1 +: 2] = pin_a1_level_i;
    pins_w[GCC_POS_A0 +: 2] = pin_a0_level_i;
    pins_w[GCC_POS_B1 +: 2] = pin_b1_level_i;
    pins_w[GCC_POS_B0 +: 2] = pin_b0_level_i;
  end

  // Go bits read zero; halt bits show their pending state
  always_comb
  begin
    ctrl_w = GCC_CONV_CTRL_RESET;
    ctrl_w[GCC_BIT_CH1_HALT] = halt1_q;
    ctrl_w[GCC_BIT_CH2_HALT] = halt2_q;
    ctrl_w[GCC_BIT_SEQ_HALT] = shalt_q;
  end

  // Registered read data, zero for unmapped addresses
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      rd_data_o <= 16'h0000;
    else if (rd_addr_i == GCC_ADDR_READBACK)
      rd_data_o <= pins_w;
    else if (rd_addr_i == GCC_ADDR_CONV_CTRL)
      rd_data_o <= ctrl_w;
    else
      rd_data_o <= 16'h0000;
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  AST_GO_BEATS_HALT1:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (w_go1 && w_halt1) |=> !halt1_q)
    else $error("channel 1 halt kept despite go");

  AST_GO_BEATS_HALT2:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (w_go2 && w_halt2) |=> !halt2_q)
    else $error("channel 2 halt kept despite go");

  AST_HALT1_SET:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (w_halt1 && !w_go1 && chan1_i.continuous) |=> halt1_q)
    else $error("channel 1 halt not taken");

  AST_HALT2_SET:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (w_halt2 && !w_go2 && chan2_i.continuous) |=> halt2_q)
    else $error("channel 2 halt not taken");

  AST_HALT2_SINGLE:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (!halt2_q && w_halt2 && !chan2_i.continuous) |=> !halt2_q)
    else $error("channel 2 halt acted in single-shot mode");

  AST_HALT1_CLEAR:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (halt1_q && chan1_i.done && !ctrl_wr) |=> !halt1_q)
    else $error("channel 1 halt did not self-clear");

  AST_HALT2_CLEAR:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (halt2_q && chan2_i.done && !ctrl_wr) |=> !halt2_q)
    else $error("channel 2 halt did not self-clear");

  AST_START_ENABLED:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      chan1_start_o |-> (chan1_i.enabled && w_go1))
    else $error("start issued to disabled channel");

  AST_SEQ_GO_READ_ZERO:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (rd_addr_i == GCC_ADDR_CONV_CTRL) |=>
        (rd_data_o[GCC_BIT_SEQ_GO] == 1'b0
         && rd_data_o[GCC_BIT_CH1_GO] == 1'b0))
    else $error("go bit read back as one");

  AST_READBACK_A1:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (rd_addr_i == GCC_ADDR_READBACK) |=>
        rd_data_o[GCC_POS_A1 +: 2] == $past(pin_a1_level_i))
    else $error("pin a1 field wrong");

  AST_READBACK_B0:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (rd_addr_i == GCC_ADDR_READBACK) |=>
        rd_data_o[GCC_POS_B0 +: 2] == $past(pin_b0_level_i))
    else $error("pin b0 field wrong");

  AST_READBACK_RSVD:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (rd_addr_i == GCC_ADDR_READBACK) |=>
        (rd_data_o[15:12] == 4'h0 && rd_data_o[7:4] == 4'h0))
    else $error("reserved readback bits not zero");

  AST_GO_CLEARS_HALT1:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (halt1_q && w_go1) |=> !halt1_q)
    else $error("channel 1 halt survived a go");

  AST_GO_CLEARS_HALT2:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (halt2_q && w_go2) |=> !halt2_q)
    else $error("channel 2 halt survived a go");

  AST_HALT2_HOLD:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (halt2_q && chan2_i.busy && !chan2_i.done && !w_go2) |=> halt2_q)
    else $error("channel 2 halt dropped before conversion end");

  AST_HALT1_SINGLE:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (!halt1_q && w_halt1 && !chan1_i.continuous) |=> !halt1_q)
    else $error("channel 1 halt acted in single-shot mode");

  AST_START2_ENABLED:
    assert property (@(posedge mclk_i) disable iff (reset_i)
      (w_go2 && chan2_i.enabled) |-> chan2_start_o)
    else $error("channel 2 start not issued");

endmodule : gcc_ctrl

/* rtl/gcc_pkg.sv */
// Package of constants and types for the readback and conversion control
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package gcc_pkg;

  localparam logic [7:0]  GCC_ADDR_READBACK = 8'h08;
  localparam logic [7:0]  GCC_ADDR_CONV_CTRL = 8'h09;
  localparam logic [15:0] GCC_READBACK_RESET = 16'h0000;
  localparam logic [15:0] GCC_CONV_CTRL_RESET = 16'h0000;

  // Field positions in the conversion control register
  localparam int GCC_BIT_CH1_GO   = 14;
  localparam int GCC_BIT_CH2_GO   = 12;
  localparam int GCC_BIT_CH1_HALT = 10;
  localparam int GCC_BIT_CH2_HALT = 8;
  localparam int GCC_BIT_SEQ_GO   = 6;
  localparam int GCC_BIT_SEQ_HALT = 2;

  // Field positions in the readback register
  localparam int GCC_POS_A1 = 10;
  localparam int GCC_POS_A0 = 8;
  localparam int GCC_POS_B1 = 2;
  localparam int GCC_POS_B0 = 0;

  // Readback level codes
  localparam logic [1:0] GCC_LVL_LOW       = 2'h0;
  localparam logic [1:0] GCC_LVL_WEAK_LOW  = 2'h1;
  localparam logic [1:0] GCC_LVL_WEAK_HIGH = 2'h2;
  localparam logic [1:0] GCC_LVL_HIGH      = 2'h3;

  // Register write frame as decoded by the serial interface
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [15:0] data;
  } gcc_wr_t;

  // Per-channel status from a current converter
  typedef struct packed {
    logic enabled;
    logic continuous;
    logic busy;
    logic done;
  } gcc_chan_t;

endpackage : gcc_pkg

/* testbench/gcc_ctrl_tb.sv */
// Self-checking testbench for the readback and conversion control block
`timescale 1ns/1ps
module gcc_ctrl_tb;
  import gcc_pkg::*;
  // ------------------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------------------
  logic        mclk_i     = 1'b0;
  logic        reset_i    = 1'b1;
  gcc_wr_t     wr_i       = '0;
  logic [7:0]  rd_addr_i  = 8'h00;
  logic [7:0]  pins       = 8'h00;
  gcc_chan_t   chan1_i    = '0;
  gcc_chan_t   chan2_i    = '0;
  logic        seq_busy_i = 1'b0;
  logic [15:0] rd_data_o;
  wire  [5:0]  st;
  logic [31:0] seed       = 32'd61;
  int          n_mismatch = 0;
  int          comparisons = 0;

  gcc_ctrl dut (.mclk_i(mclk_i), .reset_i(reset_i), .wr_i(wr_i),
    .rd_addr_i(rd_addr_i), .pin_a1_level_i(pins[7:6]),
    .pin_a0_level_i(pins[5:4]), .pin_b1_level_i(pins[3:2]),
    .pin_b0_level_i(pins[1:0]), .chan1_i(chan1_i), .chan2_i(chan2_i),
    .seq_busy_i(seq_busy_i), .rd_data_o(rd_data_o),
    .chan1_start_o(st[5]), .chan2_start_o(st[4]), .seq_start_o(st[3]),
    .chan1_stop_o(st[2]), .chan2_stop_o(st[1]), .seq_stop_o(st[0]));

  // Free-running clock, 40 ns period
  initial
  begin
    forever #20 mclk_i = ~mclk_i;
  end

  // ------------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Reserved nibbles always read zero around the four level fields
  function automatic logic [15:0] exp_rb(input logic [7:0] p);
    return {4'h0, p[7:4], 4'h0, p[3:0]};
  endfunction : exp_rb

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_ctl(input logic [5:0] got, input logic [5:0] exp);
    chk_reg({10'h000, got}, {10'h000, exp});
  endtask : chk_ctl

  // Start pulses are combinational, so they are looked at inside the frame;
  // an idle cycle follows so valid is never driven twice in one time step
  task automatic wr(input logic [15:0] d, input logic [5:0] e);
    wr_i = '{1'b1, GCC_ADDR_CONV_CTRL, d};
    #1 chk_ctl(st, e);
    @(negedge mclk_i);
    wr_i = '0;
    @(negedge mclk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rd_addr_i = a;
    @(negedge mclk_i);
    chk_reg(rd_data_o, e);
  endtask : rd

  task automatic give_verdict();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------------
  initial
  begin
    repeat (2) @(negedge mclk_i);
    chk_ctl(st, 6'h00);
    reset_i = 1'b0;
    rd(GCC_ADDR_CONV_CTRL, GCC_CONV_CTRL_RESET);
    rd(GCC_ADDR_READBACK, GCC_READBACK_RESET);
    // Corner codes first, then random pin levels
    for (int i = 0; i < 24; i++)
    begin
      seed = xs(seed);
      pins = (i == 0) ? 8'hff : (i == 1) ? 8'he4 : seed[7:0];
      rd(GCC_ADDR_READBACK, exp_rb(pins));
    end
    rd(seed[15:8] | 8'h10, 16'h0000);
    $display("test readback done");
    // Both channels continuous and busy; halts wait for each done
    chan1_i = '{1'b1, 1'b1, 1'b1, 1'b0};
    chan2_i = '{1'b1, 1'b1, 1'b1, 1'b0};
    wr(16'h0500, 6'h00);
    repeat (3) @(negedge mclk_i);
    chk_ctl(st, 6'b000110);
    rd(GCC_ADDR_CONV_CTRL, 16'h0500);
    chan1_i.done = 1'b1;
    @(negedge mclk_i);
    chan1_i.done = 1'b0;
    chk_ctl(st, 6'b000010);
    chan2_i.done = 1'b1;
    @(negedge mclk_i);
    chan2_i.done = 1'b0;
    chk_ctl(st, 6'h00);
    // Go and halt in one frame: go wins, go bits read zero
    wr(16'h5500, 6'b110000);
    chk_ctl(st, 6'h00);
    rd(GCC_ADDR_CONV_CTRL, 16'h0000);
    // Go while halt pending: halts still show in the go frame, then clear
    wr(16'h0500, 6'h00);
    wr(16'h4000, 6'b100110);
    chk_ctl(st, 6'b000010);
    wr(16'h1000, 6'b010010);
    chk_ctl(st, 6'h00);
    $display("test continuous done");
    // Single-shot halts and disabled goes are refused
    chan1_i.continuous = 1'b0;
    chan2_i.continuous = 1'b0;
    wr(16'h0500, 6'h00);
    chk_ctl(st, 6'h00);
    chan1_i.enabled = 1'b0;
    chan2_i.enabled = 1'b0;
    wr(16'h5000, 6'h00);
    $display("test refused done");
    // Sequencer go pulses; the pending halt is visible in the go frame
    seq_busy_i = 1'b1;
    wr(16'h0040, 6'b001000);
    wr(16'h0004, 6'h00);
    rd(GCC_ADDR_CONV_CTRL, 16'h0004);
    wr(16'h0040, 6'b001001);
    chk_ctl(st, 6'h00);
    wr(16'h0004, 6'h00);
    chk_ctl(st, 6'b000001);
    seq_busy_i = 1'b0;
    @(negedge mclk_i);
    chk_ctl(st, 6'h00);
    $display("test sequencer done");
    give_verdict();
  end
endmodule : gcc_ctrl_tb
